// *** hdl/psf_pkg.sv ***
package psf_pkg;
    // Register map
    localparam logic [11:0] STATUS_OFFSET = 12'h00D0;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // Status word field positions
    localparam int CARRY_BIT = 7;
    localparam int HALF_CARRY_BIT = 6;
    localparam int USER0_BIT = 5;
    localparam int BANK_HI_BIT = 4;
    localparam int BANK_LO_BIT = 3;
    localparam int EXCESS_BIT = 2;
    localparam int USER1_BIT = 1;
    localparam int PARITY_BIT = 0;
    // Working register layout
    localparam int REGS_PER_BANK = 8;
    localparam int REG_IDX_W = 3;
    localparam int BANK_W = 2;
    // APB answer timing: one wait cycle in the access phase
    localparam int APB_WAIT_CYCLES = 1;

    // Arithmetic operations that update the flags
    typedef enum logic [2:0] {
        ALU_ADD = 3'b001,
        ALU_ADDC = 3'b010,
        ALU_SUBB = 3'b100
    } psf_alu_op_t;

    // Bit operations on the carry flag
    typedef enum logic [7:0] {
        BIT_SETC = 8'b0000_0001,
        BIT_CLRC = 8'b0000_0010,
        BIT_CPLC = 8'b0000_0100,
        BIT_ANLC = 8'b0000_1000,
        BIT_ANLNC = 8'b0001_0000,
        BIT_ORLC = 8'b0010_0000,
        BIT_ORLNC = 8'b0100_0000,
        BIT_MOVC = 8'b1000_0000
    } psf_bit_op_t;
endpackage

// *** hdl/psf_flag_calc.sv ***
`timescale 1ns/1ns
// Adder with the carry taps the status flags need; subtract is add of the complement
module psf_flag_calc
    import psf_pkg::*;
(
    // Operands
    input wire logic [7:0] opA,
    input wire logic [7:0] opB,
    input wire logic carryIn,
    input wire logic subtract,
    // Results
    output logic [7:0] sum,
    output logic carryOut,
    output logic halfCarry,
    output logic excess
);
    logic [7:0] bEff;
    logic cEff;
    logic [4:0] lowNib;
    logic [7:0] low7;
    logic [8:0] full;

    // Borrow of a subtract is the inverted carry of the complement add
    always_comb begin
        bEff = subtract ? ~opB : opB;
        cEff = subtract ? ~carryIn : carryIn;
        lowNib = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, cEff};
        low7 = {1'b0, opA[6:0]} + {1'b0, bEff[6:0]} + {7'h00, cEff};
        full = {1'b0, opA} + {1'b0, bEff} + {8'h00, cEff};
        sum = full[7:0];
        carryOut = full[8] ^ subtract;
        halfCarry = lowNib[4] ^ subtract;
        excess = low7[7] ^ full[8];
    end
endmodule

// *** hdl/psf_bank_map.sv ***
`timescale 1ns/1ns
// Maps a working-register index onto the data address of the selected bank
module psf_bank_map
    import psf_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Request
    input wire logic [BANK_W-1:0] bank,
    input wire logic [REG_IDX_W-1:0] regIdx,
    // Mapped address
    output logic [7:0] regAddr
);
    logic [7:0] regAddr_r;
    logic [7:0] regAddr_nxt;

    // Bank times eight plus index; bank comes from the stored word, so a change counts next
    always_comb begin
        regAddr_nxt = 8'(bank) * 8'(REGS_PER_BANK) + 8'(regIdx);
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            regAddr_r <= 8'h00;
        end else begin
            regAddr_r <= regAddr_nxt;
        end
    end

    assign regAddr = regAddr_r;
endmodule

// *** hdl/psf_status_word.sv ***
`timescale 1ns/1ns
// Processor status word: arithmetic flags, user flags, bank select and parity
module psf_status_word
    import psf_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Arithmetic datapath
    input wire logic aluValid,
    input wire logic [2:0] aluOp,
    input wire logic [7:0] aluOpA,
    input wire logic [7:0] aluOpB,
    output logic [7:0] aluSum,
    // Bit datapath
    input wire logic bitValid,
    input wire logic [7:0] bitOp,
    input wire logic bitIn,
    output logic bitOut,
    // Accumulator and working registers
    input wire logic [7:0] accumulator,
    input wire logic [REG_IDX_W-1:0] regIdx,
    output logic [7:0] regAddr,
    // Status word to the core
    output logic [7:0] statusWord
);
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
        $error("psf_status_word: ADDR_W must lie in 8..32");
    end
    // The pready pulse below is built for exactly one wait cycle
    if (APB_WAIT_CYCLES != 1) begin : g_wait_chk
        $error("psf_status_word: the bus answer logic serves one wait cycle only");
    end

    logic [7:1] flags_r;
    logic [7:1] flags_nxt;
    logic parity_r;
    logic parity_nxt;
    logic [7:0] aluSum_r;
    logic [7:0] aluSum_nxt;
    logic bitOut_r;
    logic bitOut_nxt;
    logic pready_r;
    logic pready_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic hit;
    logic accept;
    logic swWrite;
    logic [7:0] calcSum;
    logic calcCarry;
    logic calcHalf;
    logic calcExcess;
    logic carryInUse;

    // Address decode; full-width compare so aliases above the map do not hit
    assign hit = (paddr == ADDR_W'(STATUS_OFFSET));
    assign accept = psel && penable && pready_r;
    assign swWrite = accept && pwrite && hit && pstrb[0];

    // ADDC and SUBB feed the stored carry in; ADD does not
    assign carryInUse = (aluOp == ALU_ADD) ? 1'b0 : flags_r[CARRY_BIT];

    psf_flag_calc u_calc (
        .opA(aluOpA),
        .opB(aluOpB),
        .carryIn(carryInUse),
        .subtract(aluOp == ALU_SUBB),
        .sum(calcSum),
        .carryOut(calcCarry),
        .halfCarry(calcHalf),
        .excess(calcExcess)
    );

    psf_bank_map u_bank (
        .mclk(mclk),
        .nrst(nrst),
        .bank(flags_r[BANK_HI_BIT:BANK_LO_BIT]),
        .regIdx(regIdx),
        .regAddr(regAddr)
    );

    // APB answer: one wait cycle, then pready with data and error together
    always_comb begin
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        prdata_nxt = 32'h0000_0000;
        if (pready_nxt) begin
            pslverr_nxt = !hit;
            if (hit && !pwrite) begin
                prdata_nxt = {24'h00_0000, flags_r, parity_r};
            end
        end
    end

    // Flags: software first, then hardware, so a datapath event wins the flags it updates over a same-cycle write
    always_comb begin
        flags_nxt = flags_r;
        aluSum_nxt = aluSum_r;
        bitOut_nxt = bitOut_r;
        if (swWrite) begin
            flags_nxt = pwdata[7:1];
        end
        if (aluValid) begin
            aluSum_nxt = calcSum;
            flags_nxt[CARRY_BIT] = calcCarry;
            flags_nxt[HALF_CARRY_BIT] = calcHalf;
            flags_nxt[EXCESS_BIT] = calcExcess;
        end else if (bitValid) begin
            unique case (bitOp)
                BIT_SETC: flags_nxt[CARRY_BIT] = 1'b1;
                BIT_CLRC: flags_nxt[CARRY_BIT] = 1'b0;
                BIT_CPLC: flags_nxt[CARRY_BIT] = !flags_r[CARRY_BIT];
                BIT_ANLC: flags_nxt[CARRY_BIT] = flags_r[CARRY_BIT] & bitIn;
                BIT_ANLNC: flags_nxt[CARRY_BIT] = flags_r[CARRY_BIT] & !bitIn;
                BIT_ORLC: flags_nxt[CARRY_BIT] = flags_r[CARRY_BIT] | bitIn;
                BIT_ORLNC: flags_nxt[CARRY_BIT] = flags_r[CARRY_BIT] | !bitIn;
                BIT_MOVC: flags_nxt[CARRY_BIT] = bitIn;
                default: flags_nxt[CARRY_BIT] = flags_r[CARRY_BIT];
            endcase
            bitOut_nxt = flags_nxt[CARRY_BIT];
        end
    end

    // Parity ignores the bus entirely, so a written bit 0 is never stored
    always_comb begin
        parity_nxt = ^accumulator;
    end

    // Register all state
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flags_r <= STATUS_RESET[7:1];
            parity_r <= STATUS_RESET[PARITY_BIT];
            aluSum_r <= 8'h00;
            bitOut_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            flags_r <= flags_nxt;
            parity_r <= parity_nxt;
            aluSum_r <= aluSum_nxt;
            bitOut_r <= bitOut_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign aluSum = aluSum_r;
    assign bitOut = bitOut_r;
    assign statusWord = {flags_r, parity_r};

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    add_carry_a: assert property (
        aluValid && aluOp == ALU_ADD
        |=> statusWord[CARRY_BIT] == ((({1'b0, $past(aluOpA)} + {1'b0, $past(aluOpB)})
            >> 8) != 9'h000)
    ) else $error("carry flag wrong after ADD");

    bit_carry_a: assert property (
        !aluValid && bitValid && bitOp == BIT_MOVC
        |=> statusWord[CARRY_BIT] == $past(bitIn) && bitOut == $past(bitIn)
    ) else $error("carry flag not loaded by bit move");

    half_carry_a: assert property (
        aluValid && aluOp == ALU_ADD
        |=> statusWord[HALF_CARRY_BIT] ==
            ((({1'b0, $past(aluOpA[3:0])} + {1'b0, $past(aluOpB[3:0])}) >> 4) != 5'h00)
    ) else $error("half carry wrong after ADD");

    user_zero_a: assert property (
        swWrite |=> statusWord[USER0_BIT] == $past(pwdata[USER0_BIT])
    ) else $error("user flag zero not written");

    bank_addr_a: assert property (
        nrst |=> regAddr == {3'b000, $past(statusWord[BANK_HI_BIT:BANK_LO_BIT]), $past(regIdx)}
    ) else $error("working register address wrong");

    excess_flag_a: assert property (
        aluValid && aluOp == ALU_ADD && aluOpA == 8'h7F && aluOpB == 8'h01
        |=> statusWord[EXCESS_BIT] && !statusWord[CARRY_BIT]
    ) else $error("overflow flag missing on 7F plus 01");

    user_one_a: assert property (
        swWrite |=> statusWord[USER1_BIT] == $past(pwdata[USER1_BIT])
    ) else $error("user flag one not written");

    parity_track_a: assert property (
        nrst |=> statusWord[PARITY_BIT] == ^$past(accumulator)
    ) else $error("parity does not follow accumulator");

    read_back_a: assert property (
        psel && penable && !pready && !pwrite && hit
        |=> pready && !pslverr && prdata[7:0] == $past(statusWord) && prdata[31:8] == 24'h0
    ) else $error("status word read back wrong");

    bank_switch_a: assert property (
        swWrite && !aluValid ##1 1'b1
        |=> regAddr[4:3] == $past(pwdata[BANK_HI_BIT:BANK_LO_BIT], 2)
    ) else $error("bank change not used by next access");

    parity_write_a: assert property (
        swWrite && $stable(accumulator) && pwdata[0] != ^accumulator
        |=> statusWord[PARITY_BIT] == ^$past(accumulator)
    ) else $error("parity bit took a software write");

    // Arithmetic results for any operands, not only the fixed example above
    add_sum_a: assert property (
        aluValid && aluOp == ALU_ADD
        |=> aluSum == 8'($past(aluOpA) + $past(aluOpB))
    ) else $error("sum wrong after ADD");

    addc_carry_a: assert property (
        aluValid && aluOp == ALU_ADDC
        |=> statusWord[CARRY_BIT] == (9'($past(aluOpA)) + 9'($past(aluOpB))
            + 9'($past(statusWord[CARRY_BIT])) > 9'h0FF)
    ) else $error("carry flag wrong after ADDC");

    subb_borrow_a: assert property (
        aluValid && aluOp == ALU_SUBB
        |=> statusWord[CARRY_BIT] == (9'($past(aluOpA))
            < 9'($past(aluOpB)) + 9'($past(statusWord[CARRY_BIT])))
    ) else $error("borrow wrong after SUBB");

    subb_half_a: assert property (
        aluValid && aluOp == ALU_SUBB
        |=> statusWord[HALF_CARRY_BIT] == (5'($past(aluOpA[3:0]))
            < 5'($past(aluOpB[3:0])) + 5'($past(statusWord[CARRY_BIT])))
    ) else $error("half borrow wrong after SUBB");

    add_excess_a: assert property (
        aluValid && aluOp == ALU_ADD
        |=> statusWord[EXCESS_BIT] == ($past(aluOpA[7]) == $past(aluOpB[7])
            && aluSum[7] != $past(aluOpA[7]))
    ) else $error("overflow flag wrong after ADD");

    // Bit operations: the ALU wins a shared cycle, odd codes leave the carry alone
    bit_priority_a: assert property (
        aluValid && bitValid |=> bitOut == $past(bitOut)
    ) else $error("bit operation not ignored beside an arithmetic one");

    cplc_flip_a: assert property (
        !aluValid && bitValid && bitOp == BIT_CPLC
        |=> statusWord[CARRY_BIT] != $past(statusWord[CARRY_BIT])
    ) else $error("carry not inverted by complement");

    illegal_bit_a: assert property (
        !aluValid && bitValid && !$onehot(bitOp) && !swWrite
        |=> statusWord[CARRY_BIT] == $past(statusWord[CARRY_BIT])
    ) else $error("carry changed by an unknown bit operation");

    // Software side: only a write moves the user flags and the bank
    user_hold_a: assert property (
        !swWrite |=> statusWord[USER0_BIT] == $past(statusWord[USER0_BIT])
            && statusWord[USER1_BIT] == $past(statusWord[USER1_BIT])
            && statusWord[BANK_HI_BIT:BANK_LO_BIT] == $past(statusWord[BANK_HI_BIT:BANK_LO_BIT])
    ) else $error("software flags moved without a write");

    apb_wait_a: assert property (
        psel && penable && !pready |=> pready
    ) else $error("bus answer not given after one wait cycle");

    pready_pulse_a: assert property (
        pready |=> !pready
    ) else $error("bus ready held longer than one cycle");

    idle_bus_a: assert property (
        !pready |-> prdata == 32'h0000_0000 && !pslverr
    ) else $error("read data or error shown outside an answer");

    unmapped_err_a: assert property (
        psel && penable && !pready && !hit
        |=> pready && pslverr && prdata == 32'h0000_0000
    ) else $error("unmapped access not refused");

    refused_write_a: assert property (
        psel && penable && pready && pwrite && !(hit && pstrb[0]) && !aluValid && !bitValid
        |=> statusWord[CARRY_BIT:USER1_BIT] == $past(statusWord[CARRY_BIT:USER1_BIT])
    ) else $error("refused write changed the status word");

    c_write_cov: cover property (swWrite);
    c_subb_cov: cover property (aluValid && aluOp == ALU_SUBB && calcCarry);
    c_bitop_cov: cover property (!aluValid && bitValid && bitOp == BIT_CPLC);
    c_err_cov: cover property (pready && pslverr);
    c_bank_cov: cover property (swWrite && pwdata[BANK_HI_BIT:BANK_LO_BIT] == 2'b11);
endmodule

// *** verif/psf_core_model.sv ***
`timescale 1ns/1ns
// Core datapath stand-in: issues one-cycle arithmetic and bit requests
module psf_core_model
    import psf_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Arithmetic request
    output logic aluValid,
    output logic [2:0] aluOp,
    output logic [7:0] aluOpA,
    output logic [7:0] aluOpB,
    // Bit request
    output logic bitValid,
    output logic [7:0] bitOp,
    output logic bitIn
);
    // Idle values at time zero
    initial begin
        aluValid = 1'b0;
        aluOp = 3'h0;
        aluOpA = 8'h00;
        aluOpB = 8'h00;
        bitValid = 1'b0;
        bitOp = 8'h00;
        bitIn = 1'b0;
    end

    // One arithmetic pulse; operands scrambled after so stale data never looks valid
    task automatic alu(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
        @(posedge mclk);
        aluValid <= 1'b1;
        aluOp <= op;
        aluOpA <= a;
        aluOpB <= b;
        @(posedge mclk);
        aluValid <= 1'b0;
        aluOpA <= ~a;
        aluOpB <= ~b;
    endtask

    // One bit-operation pulse on the carry
    task automatic bitop(input logic [7:0] op, input logic bi);
        @(posedge mclk);
        bitValid <= 1'b1;
        bitOp <= op;
        bitIn <= bi;
        @(posedge mclk);
        bitValid <= 1'b0;
        bitIn <= ~bi;
    endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ns
// Self-checking bench for the status word
module testbench
    import psf_pkg::*;
;
    typedef struct {
        logic isBit;
        logic [7:0] op, a, b;
        logic cin;
        logic [7:0] sum;
        logic [2:0] flg;
    } psf_row_t;
    // Rows: flg is {carry, half, excess}; bit rows use a[0] as operand, flg[2] as carry
    psf_row_t rows [16] = '{
        '{1'b0, 8'h01, 8'h7F, 8'h01, 1'b0, 8'h80, 3'b011},
        '{1'b0, 8'h01, 8'hFF, 8'h01, 1'b0, 8'h00, 3'b110},
        '{1'b0, 8'h02, 8'h80, 8'h80, 1'b1, 8'h01, 3'b101},
        '{1'b0, 8'h02, 8'h0F, 8'h00, 1'b1, 8'h10, 3'b010},
        '{1'b0, 8'h04, 8'h00, 8'h01, 1'b0, 8'hFF, 3'b110},
        '{1'b0, 8'h04, 8'h80, 8'h01, 1'b0, 8'h7F, 3'b011},
        '{1'b0, 8'h04, 8'h10, 8'h00, 1'b1, 8'h0F, 3'b010},
        '{1'b1, 8'h01, 8'h00, 8'h00, 1'b0, 8'h00, 3'b100},
        '{1'b1, 8'h02, 8'h00, 8'h00, 1'b1, 8'h00, 3'b000},
        '{1'b1, 8'h04, 8'h00, 8'h00, 1'b1, 8'h00, 3'b000},
        '{1'b1, 8'h08, 8'h00, 8'h00, 1'b1, 8'h00, 3'b000},
        '{1'b1, 8'h10, 8'h00, 8'h00, 1'b1, 8'h00, 3'b100},
        '{1'b1, 8'h20, 8'h01, 8'h00, 1'b0, 8'h00, 3'b100},
        '{1'b1, 8'h40, 8'h01, 8'h00, 1'b0, 8'h00, 3'b000},
        '{1'b1, 8'h03, 8'h00, 8'h00, 1'b1, 8'h00, 3'b100},
        '{1'b1, 8'h80, 8'h01, 8'h00, 1'b0, 8'h00, 3'b100}};
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic pready, pslverr, er, aluValid, bitValid, bitIn, bitOut;
    logic [2:0] aluOp;
    logic [7:0] aluOpA, aluOpB, aluSum, bitOp, statusWord, regAddr;
    logic [7:0] accumulator = 8'h00;
    logic [2:0] regIdx = 3'h0;
    int errorCnt = 0, numChecks = 0, cycles = 0;

    psf_status_word i_psf_status_word (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .aluValid(aluValid),
        .aluOp(aluOp), .aluOpA(aluOpA), .aluOpB(aluOpB), .aluSum(aluSum),
        .bitValid(bitValid), .bitOp(bitOp), .bitIn(bitIn), .bitOut(bitOut),
        .accumulator(accumulator), .regIdx(regIdx), .regAddr(regAddr),
        .statusWord(statusWord));
    psf_core_model i_psf_core_model (.mclk(mclk), .aluValid(aluValid), .aluOp(aluOp),
        .aluOpA(aluOpA), .aluOpB(aluOpB), .bitValid(bitValid), .bitOp(bitOp), .bitIn(bitIn));

    // 10 MHz clock
    always #50 mclk = ~mclk;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            conclude();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // APB master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        check({pready, statusWord, regAddr}, 32'h0000_0000);
        nrst <= 1'b1;
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0000);
        check(er, 1'b0);
        $display("test reset done");
        // Table of arithmetic and bit operations, carry preset by software
        foreach (rows[i]) begin
            apb(1'b1, STATUS_OFFSET, {24'h00_0000, rows[i].cin, 7'h00}, 4'hF);
            if (rows[i].isBit)
                i_psf_core_model.bitop(rows[i].op, rows[i].a[0]);
            else
                i_psf_core_model.alu(rows[i].op[2:0], rows[i].a, rows[i].b);
            @(negedge mclk);
            if (rows[i].isBit)
                check({statusWord[7], bitOut}, {2{rows[i].flg[2]}});
            else
                check({aluSum, statusWord[7:6], statusWord[2]}, {rows[i].sum, rows[i].flg});
        end
        $display("test datapath rows done");
        // Arithmetic and bit operation in one cycle: the carry follows the ADD, bitOut stands
        fork
            i_psf_core_model.alu(ALU_ADD, 8'h01, 8'h01);
            i_psf_core_model.bitop(BIT_SETC, 1'b0);
        join
        @(negedge mclk);
        check({statusWord[7], bitOut}, 2'b01);
        $display("test same-cycle operations done");
        // User flags are written and read back, parity write is lost and follows the accumulator
        @(posedge mclk);
        accumulator <= 8'h07;
        apb(1'b1, STATUS_OFFSET, 32'hFFFF_FF22, 4'hF);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0023);
        accumulator <= 8'h03;
        apb(1'b1, STATUS_OFFSET, 32'h0000_0001, 4'hF);
        repeat (2) @(negedge mclk);
        check(statusWord, 8'h00);
        $display("test user flags and parity done");
        // Every bank; the map follows one cycle after the field changes
        @(posedge mclk);
        regIdx <= 3'h5;
        for (int b = 0; b < 4; b++) begin
            apb(1'b1, STATUS_OFFSET, 32'(b) << 3, 4'h1);
            repeat (3) @(negedge mclk);
            check({statusWord[4:3], regAddr}, {b[1:0], 8'(b * 8 + 5)});
        end
        $display("test banks done");
        // Unmapped address and a write without byte 0 strobe are refused
        apb(1'b0, 12'h0D4, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0000);
        check(er, 1'b1);
        apb(1'b1, 12'h0D4, 32'h0000_00FF, 4'hF);
        check(er, 1'b1);
        apb(1'b1, STATUS_OFFSET, 32'h0000_00FF, 4'hE);
        repeat (2) @(negedge mclk);
        check(statusWord, 8'h18);
        $display("test refusals done");
        // Reset in mid-run clears word and map; the bus answers again right after release
        @(posedge mclk);
        accumulator <= 8'h01;
        nrst <= 1'b0;
        @(negedge mclk);
        check({pready, statusWord, regAddr}, 32'h0000_0000);
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(negedge mclk);
        check({statusWord, regAddr}, 32'h0000_0105);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000, 4'hF);
        check(rd, 32'h0000_0001);
        $display("test mid-run reset done");
        conclude();
    end
endmodule
